// ==== rtl/prm_cfg.svh ====
/*
 * offsets, reset values, field positions and lane indices of the remap block.
 * assumes APB byte addressing: byte address = 4 * register index.
 */
`ifndef PRM_CFG_SVH
`define PRM_CFG_SVH
`define PRM_IDX_RMP3      12'h000
`define PRM_IDX_RMP1      12'h001
`define PRM_IDX_RMP2      12'h002
`define PRM_ADDR_RMP3     (`PRM_IDX_RMP3 * 12'h004)
`define PRM_ADDR_RMP1     (`PRM_IDX_RMP1 * 12'h004)
`define PRM_ADDR_RMP2     (`PRM_IDX_RMP2 * 12'h004)
`define PRM_RST_RMP1      8'h0C
`define PRM_RST_RMP2      8'h00
`define PRM_RST_RMP3      8'h00
`define PRM_MASK_ALL      8'hFF
`define PRM_MASK_RMP2_LM  8'h1F
`define PRM_MASK_RMP3_HI  8'h3F
`define PRM_MASK_NONE     8'h00
`define PRM_LANES         19
`define PRM_POS           3
`define PRM_DMA_CH        4
`define PRM_L_SPI1        0
`define PRM_L_U1CK        4
`define PRM_L_U1TX        5
`define PRM_L_U1RX        6
`define PRM_L_SPI2        7
`define PRM_L_T2CH1       11
`define PRM_L_T2CH2       12
`define PRM_L_T3CH1       13
`define PRM_L_T3CH2       14
`define PRM_L_U3CK        15
`define PRM_L_U3TX        16
`define PRM_L_U3RX        17
`define PRM_L_CCO         18
`define PRM_TXRX_ALT_A    2'h1
`define PRM_TXRX_ALT_B    2'h2
`endif

// ==== rtl/prm_pkg.sv ====
/*
 * types of the remap block: density variant, register layouts, trigger pins.
 * assumes prm_cfg.svh for the numeric constants.
 */
package prm_pkg;
    typedef enum {
        PRM_LOW, PRM_LOW20, PRM_MED, PRM_MEDPLUS, PRM_HIGH
    } prm_density_e;
    typedef logic [1:0] prm_pos_t;
    typedef struct packed {
        logic       serial1_pin_swap_a;
        logic       uart1_clock_pin_swap;
        logic [1:0] uart1_txrx_pin_select;
        logic [1:0] timer4_dma_channel_select;
        logic [1:0] adc_dma_channel_select;
    } prm_rmp1_s;
    typedef struct packed {
        logic timer_break_pin_swap;
        logic timer3_trigger_alt_pin;
        logic serial2_pin_swap;
        logic timer3_trigger_from_osc;
        logic timer2_trigger_from_osc;
        logic timer3_trigger_pin_swap;
        logic timer2_trigger_pin_swap;
        logic adc_trigger_pin_swap;
    } prm_rmp2_s;
    typedef struct packed {
        logic timer2_chan2_pin_swap;
        logic timer2_chan1_pin_swap;
        logic clock_out_pin_swap;
        logic timer3_chan2_pin_swap;
        logic timer3_chan1_pin_swap;
        logic uart3_clock_pin_swap;
        logic uart3_txrx_pin_swap;
        logic serial1_pin_swap_b;
    } prm_rmp3_s;
    typedef struct packed {
        logic slow_oscillator_input;
        logic pb3;
        logic pa4;
        logic pd1;
        logic pa5;
        logic pg3;
        logic pg0;
        logic pg1;
        logic pa6;
        logic pd0;
    } prm_trig_pins_s;
endpackage

// ==== rtl/prm_remap.sv ====
/*
 * peripheral signal remap: three byte registers on APB steer peripheral
 * lanes, triggers, break inputs and DMA channels onto alternative pins.
 * assumes pad inputs and the slow oscillator are asynchronous, peripheral
 * and DMA signals run on pclk, and a port mux downstream merges pad requests.
 */
// Behaviour
// - serial1 swap a moves its four lines from PB7..PB4 to PA2, PA3, PC6, PC5
// - uart1 clock on PC4 when clear, PA0 when set
// - uart1 tx/rx on PC3/PC2, PA3.. per code 00/01/10; 11 reserved
// - timer4 DMA request/ack to channel given by bits 3:2
// - ADC DMA request/ack to channel given by bits 1:0
// - register 2 at byte address 0x08, register 3 at 0x00, both reset to zero
// - timer2/3 break on PA4/PA5, or PG0/PG1 when swapped
// - timer3 trigger from slow oscillator when its osc bit set
// - timer3 pin trigger: PG3 if alt bit, else PD1 or PA5
// - timer2 trigger: oscillator if osc bit, else PB3 or PA4
// - serial2 lines on PG7..PG4, or PI3..PI0 when swapped
// - ADC trigger from PA6, or PD0 when swapped
// - register 2 bits 7:5 inert on low and medium density
// - register 3 exists only on low20, medium+ and high density
// - low20 only: reg3 bits 7/6 move timer2 ch2/ch1 to PC6/PC5
// - clock output on PC4, or PE2 when reg3 bit 5 set
// - reg3 bits 4/3 move timer3 ch2/ch1 to PI3/PI0
// - uart3 clock PG2 or PF2; tx/rx PG1/PG0 or PF0/PF1
// - reg3 bit 0 moves serial1 lines to PF0..PF3
`timescale 1ns/1ns
`include "prm_cfg.svh"
module prm_remap #(
    parameter prm_pkg::prm_density_e DENSITY = prm_pkg::PRM_HIGH
) (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic [`PRM_LANES-1:0]                 lane_periph_o,
    input  wire logic [`PRM_LANES-1:0]                 lane_periph_oe,
    output logic      [`PRM_LANES-1:0]                 lane_periph_i,
    output logic      [`PRM_LANES-1:0][`PRM_POS-1:0]   lane_pad_o,
    output logic      [`PRM_LANES-1:0][`PRM_POS-1:0]   lane_pad_oe,
    input  wire logic [`PRM_LANES-1:0][`PRM_POS-1:0]   lane_pad_i,
    input  wire prm_pkg::prm_trig_pins_s               trig_pins,
    output logic                                       timer2_trigger,
    output logic                                       timer3_trigger,
    output logic                                       timer2_break,
    output logic                                       timer3_break,
    output logic                                       adc_trigger,
    input  wire logic                                  timer4_dma_req,
    output logic                                       timer4_dma_ack,
    input  wire logic                                  adc_dma_req,
    output logic                                       adc_dma_ack,
    output logic      [`PRM_DMA_CH-1:0]                dma_req,
    input  wire logic [`PRM_DMA_CH-1:0]                dma_ack
);
    // variant decode: absent bits are never stored, so they read zero
    localparam logic HAS_RMP3 = (DENSITY == prm_pkg::PRM_LOW20) ||
                                (DENSITY == prm_pkg::PRM_MEDPLUS) ||
                                (DENSITY == prm_pkg::PRM_HIGH);
    localparam logic LOW_MED  = (DENSITY == prm_pkg::PRM_LOW) ||
                                (DENSITY == prm_pkg::PRM_LOW20) ||
                                (DENSITY == prm_pkg::PRM_MED);
    localparam logic [7:0] MASK2 = LOW_MED ? `PRM_MASK_RMP2_LM : `PRM_MASK_ALL;
    localparam logic [7:0] MASK3 = !HAS_RMP3 ? `PRM_MASK_NONE :
                                   (DENSITY == prm_pkg::PRM_LOW20) ? `PRM_MASK_ALL :
                                   `PRM_MASK_RMP3_HI;

    function automatic prm_pkg::prm_pos_t pos2(input logic swap);
        pos2 = swap ? 2'h1 : 2'h0;
    endfunction

    prm_pkg::prm_rmp1_s rmp1_reg;
    prm_pkg::prm_rmp2_s rmp2_reg;
    prm_pkg::prm_rmp3_s rmp3_reg;
    logic [31:0]        prdata_reg;

    // APB decode; zero wait states, so pready is a constant high
    logic       acc_w;
    logic       wr_w;
    logic       hit1_w;
    logic       hit2_w;
    logic       hit3_w;
    logic       hit_w;
    logic [7:0] rd_byte_w;
    assign acc_w   = psel & penable;
    assign hit1_w  = (paddr == `PRM_ADDR_RMP1);
    assign hit2_w  = (paddr == `PRM_ADDR_RMP2);
    assign hit3_w  = (paddr == `PRM_ADDR_RMP3) & HAS_RMP3;
    assign hit_w   = hit1_w | hit2_w | hit3_w;
    assign wr_w    = acc_w & pwrite & hit_w;
    assign pready  = 1'b1;
    assign pslverr = acc_w & ~hit_w;
    assign prdata  = prdata_reg;
    assign rd_byte_w = hit1_w ? rmp1_reg :
                       hit2_w ? rmp2_reg :
                       hit3_w ? rmp3_reg : 8'h00;

    // writes land at the access edge and steer routing from the next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rmp1_reg <= `PRM_RST_RMP1;
            rmp2_reg <= `PRM_RST_RMP2;
            rmp3_reg <= `PRM_RST_RMP3;
        end else if (wr_w) begin
            if (hit1_w) begin
                rmp1_reg <= pwdata[7:0];
            end
            if (hit2_w) begin
                rmp2_reg <= pwdata[7:0] & MASK2;
            end
            if (hit3_w) begin
                rmp3_reg <= pwdata[7:0] & MASK3;
            end
        end
    end

    // read data captured in the setup cycle, valid through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            prdata_reg <= {24'h00_0000, rd_byte_w};
        end
    end

    // pad and oscillator inputs come from outside pclk: two flops first
    logic [`PRM_LANES-1:0][`PRM_POS-1:0] pad_meta_reg;
    logic [`PRM_LANES-1:0][`PRM_POS-1:0] pad_sync_reg;
    prm_pkg::prm_trig_pins_s             trig_meta_reg;
    prm_pkg::prm_trig_pins_s             trig_sync_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_meta_reg  <= '0;
            pad_sync_reg  <= '0;
            trig_meta_reg <= '0;
            trig_sync_reg <= '0;
        end else begin
            pad_meta_reg  <= lane_pad_i;
            pad_sync_reg  <= pad_meta_reg;
            trig_meta_reg <= trig_pins;
            trig_sync_reg <= trig_meta_reg;
        end
    end

    // per-lane pin position: 0 default, 1 first alternative, 2 second
    prm_pkg::prm_pos_t sel_w [`PRM_LANES];
    prm_pkg::prm_pos_t spi1_pos_w;
    prm_pkg::prm_pos_t u1tr_pos_w;
    // swap a wins if software sets both serial1 swaps
    assign spi1_pos_w = rmp1_reg.serial1_pin_swap_a ? 2'h1 :
                        rmp3_reg.serial1_pin_swap_b ? 2'h2 : 2'h0;
    // reserved code 11 falls back to the default pins
    assign u1tr_pos_w =
        (rmp1_reg.uart1_txrx_pin_select == `PRM_TXRX_ALT_A) ? 2'h1 :
        (rmp1_reg.uart1_txrx_pin_select == `PRM_TXRX_ALT_B) ? 2'h2 : 2'h0;

    always_comb begin
        for (int l = 0; l < 4; l++) begin
            sel_w[`PRM_L_SPI1 + l] = spi1_pos_w;
            sel_w[`PRM_L_SPI2 + l] = pos2(rmp2_reg.serial2_pin_swap);
        end
        sel_w[`PRM_L_U1CK]  = pos2(rmp1_reg.uart1_clock_pin_swap);
        sel_w[`PRM_L_U1TX]  = u1tr_pos_w;
        sel_w[`PRM_L_U1RX]  = u1tr_pos_w;
        sel_w[`PRM_L_T2CH1] = pos2(rmp3_reg.timer2_chan1_pin_swap);
        sel_w[`PRM_L_T2CH2] = pos2(rmp3_reg.timer2_chan2_pin_swap);
        sel_w[`PRM_L_T3CH1] = pos2(rmp3_reg.timer3_chan1_pin_swap);
        sel_w[`PRM_L_T3CH2] = pos2(rmp3_reg.timer3_chan2_pin_swap);
        sel_w[`PRM_L_U3CK]  = pos2(rmp3_reg.uart3_clock_pin_swap);
        sel_w[`PRM_L_U3TX]  = pos2(rmp3_reg.uart3_txrx_pin_swap);
        sel_w[`PRM_L_U3RX]  = pos2(rmp3_reg.uart3_txrx_pin_swap);
        sel_w[`PRM_L_CCO]   = pos2(rmp3_reg.clock_out_pin_swap);
    end

    // lane steering is combinational so a write acts in the next cycle
    always_comb begin
        for (int l = 0; l < `PRM_LANES; l++) begin
            for (int p = 0; p < `PRM_POS; p++) begin
                lane_pad_o[l][p]  = (sel_w[l] == p[1:0]) & lane_periph_o[l];
                lane_pad_oe[l][p] = (sel_w[l] == p[1:0]) & lane_periph_oe[l];
            end
            lane_periph_i[l] = pad_sync_reg[l][sel_w[l]];
        end
    end

    // triggers and break inputs; software owns prescaler and oscillator setup
    prm_pkg::prm_trig_pins_s ts;
    logic                    t3_pin_w;
    assign ts = trig_sync_reg;
    assign t3_pin_w = rmp2_reg.timer3_trigger_alt_pin ? ts.pg3 :
                      rmp2_reg.timer3_trigger_pin_swap ? ts.pa5 : ts.pd1;
    assign timer3_trigger = rmp2_reg.timer3_trigger_from_osc ?
                            ts.slow_oscillator_input : t3_pin_w;
    assign timer2_trigger = rmp2_reg.timer2_trigger_from_osc ? ts.slow_oscillator_input :
                            rmp2_reg.timer2_trigger_pin_swap ? ts.pa4 : ts.pb3;
    assign timer2_break = rmp2_reg.timer_break_pin_swap ? ts.pg0 : ts.pa4;
    assign timer3_break = rmp2_reg.timer_break_pin_swap ? ts.pg1 : ts.pa5;
    assign adc_trigger  = rmp2_reg.adc_trigger_pin_swap ? ts.pd0 : ts.pa6;

    // DMA: both sources may share a channel; their requests then merge
    logic [1:0] t4ch_w;
    logic [1:0] adch_w;
    assign t4ch_w = rmp1_reg.timer4_dma_channel_select;
    assign adch_w = rmp1_reg.adc_dma_channel_select;
    always_comb begin
        for (int c = 0; c < `PRM_DMA_CH; c++) begin
            dma_req[c] = (timer4_dma_req & (t4ch_w == c[1:0])) |
                         (adc_dma_req & (adch_w == c[1:0]));
        end
    end
    assign timer4_dma_ack = dma_ack[t4ch_w];
    assign adc_dma_ack    = dma_ack[adch_w];

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_spi1_a;
        rmp1_reg.serial1_pin_swap_a |->
            lane_pad_oe[`PRM_L_SPI1][1] == lane_periph_oe[`PRM_L_SPI1] &&
            !lane_pad_oe[`PRM_L_SPI1][0] && !lane_pad_oe[`PRM_L_SPI1][2];
    endproperty
    a_spi1_a: assert property (p_spi1_a) else $error("serial1 swap a misrouted");

    property p_u1ck;
        !rmp1_reg.uart1_clock_pin_swap |->
            lane_pad_o[`PRM_L_U1CK][0] == lane_periph_o[`PRM_L_U1CK] &&
            !lane_pad_o[`PRM_L_U1CK][1];
    endproperty
    a_u1ck: assert property (p_u1ck) else $error("uart1 clock misrouted");

    property p_u1tr;
        (rmp1_reg.uart1_txrx_pin_select == 2'h2) |->
            lane_periph_i[`PRM_L_U1RX] == pad_sync_reg[`PRM_L_U1RX][2];
    endproperty
    a_u1tr: assert property (p_u1tr) else $error("uart1 rx misrouted");

    property p_t4dma;
        timer4_dma_req |-> dma_req[t4ch_w];
    endproperty
    a_t4dma: assert property (p_t4dma) else $error("timer4 request lost");

    property p_adcdma;
        !timer4_dma_req && !adc_dma_req |-> dma_req == 4'h0 ##0
            adc_dma_ack == dma_ack[rmp1_reg[1:0]];
    endproperty
    a_adcdma: assert property (p_adcdma) else $error("adc dma misrouted");

    property p_reset;
        $rose(presetn) |-> rmp1_reg == `PRM_RST_RMP1 && rmp2_reg == 8'h00 &&
            rmp3_reg == 8'h00;
    endproperty
    a_reset: assert property (@(posedge pclk) disable iff (1'b0) p_reset)
        else $error("remap reset value wrong");

    property p_brk;
        rmp2_reg.timer_break_pin_swap |-> timer2_break == ts.pg0 &&
            timer3_break == ts.pg1;
    endproperty
    a_brk: assert property (p_brk) else $error("break inputs misrouted");

    property p_t3osc;
        rmp2_reg.timer3_trigger_from_osc |->
            timer3_trigger == ts.slow_oscillator_input;
    endproperty
    a_t3osc: assert property (p_t3osc) else $error("timer3 osc trigger wrong");

    property p_t2pin;
        !rmp2_reg.timer2_trigger_from_osc && rmp2_reg.timer2_trigger_pin_swap
            |-> timer2_trigger == ts.pa4;
    endproperty
    a_t2pin: assert property (p_t2pin) else $error("timer2 trigger wrong");

    // checked through a write so the mask is exercised on every variant
    property p_inert;
        (wr_w && hit2_w) |=> rmp2_reg == ($past(pwdata[7:0]) & MASK2);
    endproperty
    a_inert: assert property (p_inert) else $error("reserved bits stored");

    property p_wr1;
        (wr_w && hit1_w) |=> rmp1_reg == $past(pwdata[7:0]);
    endproperty
    a_wr1: assert property (p_wr1) else $error("write not applied");

    property p_wr3;
        (wr_w && hit3_w) |=> rmp3_reg == ($past(pwdata[7:0]) & MASK3);
    endproperty
    a_wr3: assert property (p_wr3) else $error("reg3 write not applied");

    property p_spi1_home;
        !rmp1_reg.serial1_pin_swap_a && !rmp3_reg.serial1_pin_swap_b |->
            lane_pad_oe[`PRM_L_SPI1 + 2][0] == lane_periph_oe[`PRM_L_SPI1 + 2] &&
            lane_pad_oe[`PRM_L_SPI1 + 2][2:1] == 2'h0;
    endproperty
    a_spi1_home: assert property (p_spi1_home) else $error("serial1 home wrong");

    property p_spi1_b;
        !rmp1_reg.serial1_pin_swap_a && rmp3_reg.serial1_pin_swap_b |->
            lane_pad_o[`PRM_L_SPI1 + 3][2] == lane_periph_o[`PRM_L_SPI1 + 3] &&
            !lane_pad_o[`PRM_L_SPI1 + 3][0];
    endproperty
    a_spi1_b: assert property (p_spi1_b) else $error("serial1 swap b wrong");

    property p_u1rsv;
        (rmp1_reg.uart1_txrx_pin_select == 2'h3) |->
            lane_pad_o[`PRM_L_U1TX][0] == lane_periph_o[`PRM_L_U1TX] &&
            lane_pad_o[`PRM_L_U1TX][2:1] == 2'h0;
    endproperty
    a_u1rsv: assert property (p_u1rsv) else $error("uart1 code 11 moved pins");

    property p_adcsel;
        adc_dma_req |-> dma_req[adch_w];
    endproperty
    a_adcsel: assert property (p_adcsel) else $error("adc request lost");

    property p_spi2;
        rmp2_reg.serial2_pin_swap |->
            lane_periph_i[`PRM_L_SPI2] == pad_sync_reg[`PRM_L_SPI2][1];
    endproperty
    a_spi2: assert property (p_spi2) else $error("serial2 input wrong");

    property p_t3pin;
        !rmp2_reg.timer3_trigger_from_osc && !rmp2_reg.timer3_trigger_alt_pin &&
            !rmp2_reg.timer3_trigger_pin_swap |-> timer3_trigger == ts.pd1;
    endproperty
    a_t3pin: assert property (p_t3pin) else $error("timer3 default trigger wrong");

    property p_t3alt;
        !rmp2_reg.timer3_trigger_from_osc && rmp2_reg.timer3_trigger_alt_pin |->
            timer3_trigger == ts.pg3;
    endproperty
    a_t3alt: assert property (p_t3alt) else $error("timer3 alt trigger wrong");

    property p_t2osc;
        rmp2_reg.timer2_trigger_from_osc |->
            timer2_trigger == ts.slow_oscillator_input;
    endproperty
    a_t2osc: assert property (p_t2osc) else $error("timer2 osc trigger wrong");

    property p_adctrig;
        rmp2_reg.adc_trigger_pin_swap |-> adc_trigger == ts.pd0;
    endproperty
    a_adctrig: assert property (p_adctrig) else $error("adc trigger wrong");

    property p_brk_home;
        !rmp2_reg.timer_break_pin_swap |-> timer2_break == ts.pa4 &&
            timer3_break == ts.pa5;
    endproperty
    a_brk_home: assert property (p_brk_home) else $error("break home wrong");

    property p_cco;
        rmp3_reg.clock_out_pin_swap |->
            lane_pad_o[`PRM_L_CCO][1] == lane_periph_o[`PRM_L_CCO] &&
            !lane_pad_o[`PRM_L_CCO][0];
    endproperty
    a_cco: assert property (p_cco) else $error("clock out misrouted");

    property p_t3ch;
        rmp3_reg.timer3_chan2_pin_swap |->
            lane_periph_i[`PRM_L_T3CH2] == pad_sync_reg[`PRM_L_T3CH2][1];
    endproperty
    a_t3ch: assert property (p_t3ch) else $error("timer3 ch2 input wrong");

    property p_u3;
        rmp3_reg.uart3_txrx_pin_swap |->
            lane_pad_oe[`PRM_L_U3RX][1] == lane_periph_oe[`PRM_L_U3RX] &&
            !lane_pad_oe[`PRM_L_U3RX][0];
    endproperty
    a_u3: assert property (p_u3) else $error("uart3 rx misrouted");

    property p_t2ch;
        (DENSITY != prm_pkg::PRM_LOW20) |-> rmp3_reg[7:6] == 2'h0;
    endproperty
    a_t2ch: assert property (p_t2ch) else $error("reg3 high bits stored");

    property p_rd3;
        acc_w && (paddr == `PRM_ADDR_RMP3) |-> pslverr == !HAS_RMP3;
    endproperty
    a_rd3: assert property (p_rd3) else $error("reg3 presence wrong");

    c_txrx_rsv: cover property (rmp1_reg.uart1_txrx_pin_select == 2'h3);
    c_osc:      cover property (rmp2_reg.timer3_trigger_from_osc && rmp2_reg.timer2_trigger_from_osc);

    c_spi1_b: cover property (rmp3_reg.serial1_pin_swap_b && !rmp1_reg.serial1_pin_swap_a);
    c_shared: cover property (timer4_dma_req && adc_dma_req && t4ch_w == adch_w);
    c_err:    cover property (pslverr);
endmodule

// ==== sim/prm_far_model.sv ====
/*
 * far-side model of the remap block: pads, trigger pins, slow oscillator, dma acks.
 * assumes pclk for the dma handshake; pads change every cycle so stale data shows.
 */
`timescale 1ns/1ns
`include "prm_cfg.svh"
module prm_far_model (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                slow,
    input  wire logic [`PRM_DMA_CH-1:0]              dma_req,
    output logic      [`PRM_DMA_CH-1:0]              dma_ack,
    output logic      [`PRM_LANES-1:0][`PRM_POS-1:0] lane_pad_i,
    output prm_pkg::prm_trig_pins_s                  trig_pins
);
    logic [`PRM_DMA_CH-1:0] req_d1;
    logic [`PRM_DMA_CH-1:0] req_d2;
    initial begin
        lane_pad_i = '0;
        trig_pins = '0;
    end
    // oscillator input keeps toggling: it is running
    always @(posedge pclk) begin
        lane_pad_i <= (`PRM_LANES*`PRM_POS)'({$urandom, $urandom});
        trig_pins <= prm_pkg::prm_trig_pins_s'(10'($urandom));
    end
    // slow mode answers one cycle later, a real dma engine may lag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_d1 <= '0;
            req_d2 <= '0;
        end else begin
            req_d1 <= dma_req;
            req_d2 <= req_d1;
        end
    end
    assign dma_ack = slow ? req_d2 : req_d1;
endmodule

// ==== sim/tb_prm_remap.sv ====
/*
 * self-checking bench of the remap block: apb register traffic, routing checks
 * on every falling edge out of reset. assumes default density (high) and the far-side model.
 */
`timescale 1ns/1ns
`include "prm_cfg.svh"
module tb_prm_remap;
    localparam int BI [8] = '{6, 7, 3, 4, 2, 1, 1, 5};
    localparam logic [9:0] CORNER [11] = '{10'h0FF, 10'h1FF, 10'h2FF, 10'h244, 10'h204,
        10'h202, 10'h0C1, 10'h180, 10'h130, 10'h2A1, 10'h3AA};
    logic                                pclk, presetn, psel, penable, pwrite, pready;
    logic                                pslverr, slow, run;
    logic [11:0]                         paddr;
    logic [31:0]                         pwdata, prdata;
    logic [`PRM_LANES-1:0]               lane_periph_o, lane_periph_oe, lane_periph_i;
    logic [`PRM_LANES-1:0][`PRM_POS-1:0] lane_pad_o, lane_pad_oe, lane_pad_i, h1, h2;
    prm_pkg::prm_trig_pins_s             trig_pins, g1, g2;
    logic                                timer2_trigger, timer3_trigger, adc_trigger;
    logic                                timer2_break, timer3_break;
    logic                                timer4_dma_req, timer4_dma_ack;
    logic                                adc_dma_req, adc_dma_ack;
    logic [`PRM_DMA_CH-1:0]              dma_req, dma_ack;
    logic [7:0]                          rm [3];
    logic [`PRM_POS-1:0]                 eo, eoe;
    logic [1:0]                          p;
    int                                  mismatches, n_tests, cyc;
    prm_remap uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .lane_periph_o, .lane_periph_oe, .lane_periph_i, .lane_pad_o,
        .lane_pad_oe, .lane_pad_i, .trig_pins, .timer2_trigger, .timer3_trigger,
        .timer2_break, .timer3_break, .adc_trigger, .timer4_dma_req, .timer4_dma_ack,
        .adc_dma_req, .adc_dma_ack, .dma_req, .dma_ack);
    prm_far_model far (.pclk, .presetn, .slow, .dma_req, .dma_ack, .lane_pad_i,
        .trig_pins);
    always #5 pclk = ~pclk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // one idle edge between transfers keeps every request signal single-driven
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic acc(input logic w, input int idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        logic [7:0]  ev;
        apb(w, 12'(idx * 4), {24'h000000, d}, rd, err);
        chk(pready, 1'b1);
        if (w && idx < 3) rm[idx] = (idx == 0) ? (d & 8'h3F) : d;
        ev = (idx < 3) ? rm[idx] : 8'h00;
        if (w) chk(err, idx > 2);
        else chk({err, rd}, {idx > 2, 24'h000000, ev});
    endtask
    function automatic logic [1:0] exp_pos(input int l);
        if (l < 4) return rm[1][7] ? 2'h1 : (rm[0][0] ? 2'h2 : 2'h0);
        if (l == 4) return {1'b0, rm[1][6]};
        if (l < 7) return (rm[1][5:4] == 2'h3) ? 2'h0 : rm[1][5:4];
        if (l < 11) return {1'b0, rm[2][5]};
        return {1'b0, rm[0][BI[l-11]]};
    endfunction
    function automatic logic [4:0] exp_trig();
        logic [7:0] c;
        c = rm[2];
        return {c[3] ? g2.slow_oscillator_input : (c[1] ? g2.pa4 : g2.pb3),
                c[4] ? g2.slow_oscillator_input : (c[6] ? g2.pg3 : (c[2] ? g2.pa5 : g2.pd1)),
                c[7] ? g2.pg0 : g2.pa4, c[7] ? g2.pg1 : g2.pa5, c[0] ? g2.pd0 : g2.pa6};
    endfunction
    function automatic logic [3:0] exp_dma();
        logic [3:0] e;
        e = '0;
        if (timer4_dma_req) e[rm[1][3:2]] = 1'b1;
        if (adc_dma_req) e[rm[1][1:0]] = 1'b1;
        return e;
    endfunction
    // pad and trigger inputs pass two synchronizer stages
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h1 <= '0;
            h2 <= '0;
            g1 <= '0;
            g2 <= '0;
        end else begin
            h1 <= lane_pad_i;
            h2 <= h1;
            g1 <= trig_pins;
            g2 <= g1;
        end
    end
    always @(posedge pclk) begin
        lane_periph_o <= `PRM_LANES'($urandom);
        lane_periph_oe <= `PRM_LANES'($urandom);
        timer4_dma_req <= 1'($urandom);
        adc_dma_req <= 1'($urandom);
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    always @(negedge pclk) begin
        if (presetn === 1'b1 && run) begin
            for (int l = 0; l < `PRM_LANES; l++) begin
                p = exp_pos(l);
                eo = '0;
                eoe = '0;
                eo[p] = lane_periph_o[l];
                eoe[p] = lane_periph_oe[l];
                chk(lane_pad_o[l], eo);
                chk(lane_pad_oe[l], eoe);
                chk(lane_periph_i[l], h2[l][p]);
            end
            chk({timer2_trigger, timer3_trigger, timer2_break, timer3_break, adc_trigger},
                exp_trig());
            chk(dma_req, exp_dma());
            chk({timer4_dma_ack, adc_dma_ack},
                {dma_ack[rm[1][3:2]], dma_ack[rm[1][1:0]]});
        end
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, slow, run, timer4_dma_req, adc_dma_req} = '0;
        paddr = '0;
        pwdata = '0;
        lane_periph_o = '0;
        lane_periph_oe = '0;
        rm = '{8'h00, 8'h0C, 8'h00};
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        void'($urandom(32'hAE3DE6F7));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        run = 1'b1;
        for (int i = 0; i < 4; i++) acc(1'b0, i, 8'h00);
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, 1, {2'h0, c[1:0], c[1:0], c[1:0]});
            repeat (3) @(posedge pclk);
        end
        foreach (CORNER[i]) begin
            acc(1'b1, int'(CORNER[i][9:8]), CORNER[i][7:0]);
            acc(1'b0, int'(CORNER[i][9:8]), 8'h00);
            repeat (3) @(posedge pclk);
        end
        // mid-run reset must restore every register from non-default contents
        presetn <= 1'b0;
        rm = '{8'h00, 8'h0C, 8'h00};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) acc(1'b0, i, 8'h00);
        for (int i = 0; i < 150; i++) begin
            slow <= 1'($urandom);
            acc(1'b1, $urandom_range(0, 3), 8'($urandom));
            acc(1'b0, $urandom_range(0, 3), 8'h00);
        end
        repeat (4) @(posedge pclk);
        stop_test();
    end
endmodule
